//--- tmc_pkg.sv
// Constants shared by the temperature monitor control logic.
// Assumes a single 200 MHz clock.
package tmc_pkg;
  // Register pointers
  localparam logic [7:0] PTR_LOCAL_HIGH = 8'h00;
  localparam logic [7:0] PTR_REMOTE1_HIGH = 8'h01;
  localparam logic [7:0] PTR_REMOTE2_HIGH = 8'h02;
  localparam logic [7:0] PTR_STATUS = 8'h08;
  localparam logic [7:0] PTR_CONFIG_ONE = 8'h09;
  localparam logic [7:0] PTR_CONFIG_TWO = 8'h0a;
  localparam logic [7:0] PTR_RATE = 8'h0b;
  localparam logic [7:0] PTR_ONE_SHOT = 8'h0f;
  localparam logic [7:0] PTR_LOCAL_LOW = 8'h10;
  localparam logic [7:0] PTR_REMOTE1_LOW = 8'h11;
  localparam logic [7:0] PTR_REMOTE2_LOW = 8'h12;
  localparam logic [7:0] PTR_RESET = 8'h00;
  // Field positions
  localparam int STATUS_BUSY_BIT = 7;
  localparam int CFG1_SHUTDOWN_BIT = 6;
  localparam int CFG1_RANGE_BIT = 2;
  localparam int CFG2_RES_CORRECT_BIT = 2;
  localparam int CFG2_LOCAL_EN_BIT = 3;
  // Writable masks, reserved bits read zero
  localparam logic [7:0] CFG1_MASK = 8'h44;
  localparam logic [7:0] CFG2_MASK = 8'h3c;
  localparam logic [7:0] RATE_MASK = 8'h07;
  // Reset values
  localparam logic [7:0] CFG1_RESET = 8'h00;
  localparam logic [7:0] CFG2_RESET_SINGLE = 8'h1c;
  localparam logic [7:0] CFG2_RESET_DUAL = 8'h3c;
  localparam logic [2:0] RATE_RESET = 3'h7;
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int CONV_TIME_US = 15000;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
  localparam int IDLE_UNIT_US = 125000;
  localparam int IDLE_UNIT_CYCLES = IDLE_UNIT_US * CLK_MHZ;
  localparam logic [2:0] RATE_FASTEST = 3'h7;
endpackage

//--- tmc_sequencer.sv
// Conversion sequencer: channel walk, conversion timing and idle delay.
// Assumes control inputs come from registers on the same clock.
`timescale 1ns/1ps
module tmc_sequencer #(
  parameter int CONV_LEN = tmc_pkg::CONV_CYCLES,
  parameter int IDLE_UNIT = tmc_pkg::IDLE_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] chanEn,
  input wire logic shutdown,
  input wire logic oneShot,
  input wire logic resCorrect,
  input wire logic [2:0] rateCode,
  output logic busy,
  output logic convStart,
  output logic convDone,
  output logic [1:0] convChannel
);
  typedef enum logic [1:0] {S_SHUT = 2'b00, S_CONV = 2'b01, S_DELAY = 2'b10} tmc_seq_t;

  tmc_seq_t state, next_state;
  logic [31:0] cnt, next_cnt;
  logic [1:0] next_chan;
  logic next_start, next_done;
  logic [31:0] convLen; // Conversion length, rate independent
  logic [31:0] idleLen; // Idle gap, scaled by rate code
  logic [2:0] first, after;

  // First enabled channel at or above a start index
  function automatic logic [2:0] nextChan(input logic [2:0] from, input logic [2:0] en);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 2; i >= 0; i--) begin
      if (en[i] && (3'(i) >= from)) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  // Dropping series-R correction halves the conversion [RULE_15]
  assign convLen = resCorrect ? 32'(CONV_LEN) : 32'(CONV_LEN / 2);
  // Only the idle gap follows the rate code, halving per step up [RULE_18] [RULE_22]
  assign idleLen = 32'(IDLE_UNIT) << (tmc_pkg::RATE_FASTEST - rateCode);
  assign first = nextChan(3'h0, chanEn);
  assign after = nextChan(3'(convChannel) + 3'h1, chanEn);

  // Next-state logic driven by one down counter [RULE_23]
  always_comb begin
    next_state = state;
    next_cnt = (cnt != 32'h0) ? cnt - 32'h1 : cnt;
    next_chan = convChannel;
    next_start = 1'b0;
    next_done = 1'b0;
    unique case (state)
      S_SHUT: begin
        // Clearing shutdown resumes, a one-shot runs one pass [RULE_09] [RULE_12]
        if ((!shutdown || oneShot) && first[2]) begin
          next_state = S_CONV;
          next_chan = first[1:0];
          next_cnt = convLen - 32'h1;
          next_start = 1'b1;
        end else if (!shutdown) begin
          next_state = S_DELAY;
          next_cnt = idleLen - 32'h1;
        end
      end
      S_CONV: begin
        // One-shot is ignored here by construction [RULE_13]
        if (cnt == 32'h0) begin
          next_done = 1'b1;
          // Walk local, remote 1, remote 2, skipping disabled [RULE_17]
          if (after[2]) begin
            next_chan = after[1:0];
            next_cnt = convLen - 32'h1;
            next_start = 1'b1;
          end else if (shutdown) begin
            next_state = S_SHUT;
          end else begin
            next_state = S_DELAY;
            next_cnt = idleLen - 32'h1;
          end
        end
      end
      S_DELAY: begin
        if (shutdown && !oneShot) begin
          next_state = S_SHUT;
        end else if (oneShot || cnt == 32'h0) begin
          // Continuous run, one-shot cuts the idle short [RULE_08] [RULE_14]
          if (first[2]) begin
            next_state = S_CONV;
            next_chan = first[1:0];
            next_cnt = convLen - 32'h1;
            next_start = 1'b1;
          end else begin
            next_cnt = idleLen - 32'h1;
          end
        end
      end
      default: next_state = S_SHUT;
    endcase
  end

  // Reset lands in a spent delay, so the first pass starts at once [RULE_07]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= S_DELAY;
      cnt <= 32'h0;
      convChannel <= 2'h0;
      convStart <= 1'b0;
      convDone <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      convChannel <= next_chan;
      convStart <= next_start;
      convDone <= next_done;
      busy <= (next_state == S_CONV);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_IDLE_RUNS: assert property (state == S_DELAY && cnt == 32'h0 && !shutdown && first[2] |=> busy) // [RULE_08]
    else $error("Idle expiry did not start a conversion");
  AST_SHUT_HOLDS: assert property (state == S_SHUT && shutdown && !oneShot |=> !busy && !convStart) // [RULE_09]
    else $error("Converter ran while shut down");
  AST_BUSY_IGNORES_SHOT: assert property (busy && cnt != 32'h0 && oneShot |=> $stable(convChannel) && !convStart) // [RULE_13]
    else $error("One-shot disturbed a running conversion");
  AST_SHOT_IN_IDLE: assert property (state != S_CONV && oneShot && first[2] |=> convStart && busy) // [RULE_14]
    else $error("One-shot did not start at once");
  AST_CONV_LENGTH: assert property (convStart |-> cnt == convLen - 32'h1) // [RULE_18]
    else $error("Conversion length depends on more than correction");
  COV_SHOT: cover property (state == S_SHUT && oneShot ##1 convStart);
  COV_DELAY: cover property (convDone ##1 state == S_DELAY);
endmodule

//--- tmc_conversion_ctrl.sv
// Register side of a three channel temperature monitor: pointer, result
// and configuration registers, paired high/low reads, and the sequencer.
// Assumes the serial decoder and the analog front end share clk.
//
// How it works
// RULE_01 - Results read-only, refreshed per finished conversion
// RULE_02 - Low byte matches preceding high byte read
// RULE_03 - Host reads high byte then low byte
// RULE_04 - Two-byte read gives high, low, same conversion
// RULE_05 - Result registers are zero after reset
// RULE_06 - Status top bit shows converting, rest zero
// RULE_07 - First conversion starts right after reset
// RULE_08 - Shutdown clear means continuous paced conversion
// RULE_09 - Shutdown set finishes sequence, then stops
// RULE_10 - Range bit picks standard or extended format
// RULE_11 - Host writes zero to reserved bits
// RULE_12 - One-shot write in shutdown runs one pass
// RULE_13 - One-shot during conversion is ignored
// RULE_14 - One-shot during idle starts immediately
// RULE_15 - Correction bit; off halves conversion time
// RULE_16 - Bits 3,4,5 enable local, remote1, remote2
// RULE_17 - Order local, remote1, remote2, stop, delay
// RULE_18 - Rate code changes idle time only
// RULE_19 - Config two resets to 1c or 3c
// RULE_20 - Config one resets to zero
// RULE_21 - Pointer selects register, every write loads it; only ptrWrite loads it here, regWrite does not
// RULE_22 - Rate code doubles per step, resets seven
// RULE_23 - One counter times steps and idle gaps
`timescale 1ns/1ps
module tmc_conversion_ctrl #(
  parameter bit DUAL_REMOTE = 1'b1, // Second remote channel fitted
  parameter int CONV_LEN = tmc_pkg::CONV_CYCLES, // Cycles per conversion with correction on
  parameter int IDLE_UNIT = tmc_pkg::IDLE_UNIT_CYCLES // Idle at fastest rate
) (
  input wire logic clk,
  input wire logic sys_rst,
  // Host side, decoded serial commands
  input wire logic ptrWrite,
  input wire logic [7:0] ptrData,
  input wire logic regWrite,
  input wire logic [7:0] regWrData,
  input wire logic regRead,
  input wire logic regReadNext,
  output logic [7:0] rdData,
  output logic rdValid,
  // Analog front end
  input wire logic [15:0] feResult,
  output logic feStart,
  output logic [1:0] feChannel,
  output logic feRangeExtended,
  output logic series_res_correct_en,
  output logic busy
);
  localparam logic [7:0] CFG2_RESET = DUAL_REMOTE ? tmc_pkg::CFG2_RESET_DUAL : tmc_pkg::CFG2_RESET_SINGLE;
  localparam logic [7:0] CFG2_WMASK = DUAL_REMOTE ? tmc_pkg::CFG2_MASK : 8'h1c;

  logic [7:0] pointer; // Selected register
  logic [7:0] configOne; // Shutdown and range
  logic [7:0] configTwo; // Channel and correction enables
  logic [2:0] rateCode; // Idle pacing code
  logic [15:0] tempRes [3]; // Per channel result, high byte on top
  logic [7:0] shadowLow; // Low byte frozen at the last high read
  logic pairValid; // Shadow still belongs to the last read
  logic [1:0] pairCh; // Channel whose high byte was read last
  logic oneShot; // One cycle trigger to the sequencer
  logic seqBusy, seqStart, seqDone;
  logic [1:0] seqChannel;
  logic shutdown_select;
  logic local_channel_en;
  logic remote_two_channel_en;
  logic [2:0] chanEn;
  logic everDone; // Helper for checking reset values
  logic [1:0] doneCh; // Channel of the conversion that just ended

  // Field views of the configuration registers
  assign shutdown_select = configOne[tmc_pkg::CFG1_SHUTDOWN_BIT];
  assign local_channel_en = configTwo[tmc_pkg::CFG2_LOCAL_EN_BIT];
  assign remote_two_channel_en = configTwo[tmc_pkg::CFG2_LOCAL_EN_BIT + 2];
  // Enables of local, remote 1 and remote 2 [RULE_16]
  assign chanEn = {remote_two_channel_en, configTwo[tmc_pkg::CFG2_LOCAL_EN_BIT + 1], local_channel_en};

  // Channel of a high byte pointer, with a hit flag
  function automatic logic [2:0] highOf(input logic [7:0] p);
    logic [2:0] r;
    r = 3'h0;
    if (p <= tmc_pkg::PTR_REMOTE2_HIGH) begin
      r = {1'b1, p[1:0]};
    end
    return r;
  endfunction

  // Channel of a low byte pointer, with a hit flag
  function automatic logic [2:0] lowOf(input logic [7:0] p);
    logic [2:0] r;
    r = 3'h0;
    if (p >= tmc_pkg::PTR_LOCAL_LOW && p <= tmc_pkg::PTR_REMOTE2_LOW) begin
      r = {1'b1, p[1:0]};
    end
    return r;
  endfunction

  // Live value of a register; unmapped and write-only read zero
  function automatic logic [7:0] liveValue(input logic [7:0] p);
    logic [7:0] v;
    v = 8'h00;
    if (highOf(p) != 3'h0) begin
      v = tempRes[p[1:0]][15:8];
    end else if (lowOf(p) != 3'h0) begin
      v = tempRes[p[1:0]][7:0];
    end else begin
      unique case (p)
        // Only the busy bit is ever nonzero [RULE_06]
        tmc_pkg::PTR_STATUS: v = {seqBusy, 7'h00};
        tmc_pkg::PTR_CONFIG_ONE: v = configOne;
        tmc_pkg::PTR_CONFIG_TWO: v = configTwo;
        tmc_pkg::PTR_RATE: v = {5'h00, rateCode};
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  // Pointer: loaded by every pointer write command, not by data writes [RULE_21]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pointer <= tmc_pkg::PTR_RESET;
    end else if (ptrWrite) begin
      pointer <= ptrData;
    end
  end

  // Configuration registers; reserved bits are not stored, so a host that
  // breaks the write-zero convention cannot reach hidden state [RULE_11]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      configOne <= tmc_pkg::CFG1_RESET; // [RULE_20]
      configTwo <= CFG2_RESET; // [RULE_19]
      rateCode <= tmc_pkg::RATE_RESET; // [RULE_22]
    end else if (regWrite) begin
      unique case (pointer)
        // Shutdown and range bits [RULE_08] [RULE_10]
        tmc_pkg::PTR_CONFIG_ONE: configOne <= regWrData & tmc_pkg::CFG1_MASK;
        // Enables and correction [RULE_15] [RULE_16]
        tmc_pkg::PTR_CONFIG_TWO: configTwo <= regWrData & CFG2_WMASK;
        tmc_pkg::PTR_RATE: rateCode <= regWrData[2:0];
        default: ;
      endcase
    end
  end

  // One-shot: the data byte is dropped, only the write event counts [RULE_12]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oneShot <= 1'b0;
    end else begin
      oneShot <= regWrite && (pointer == tmc_pkg::PTR_ONE_SHOT);
    end
  end

  // Channel one cycle late. The done pulse comes out on the same edge
  // that moves the sequencer to its next channel, so the live channel
  // would file the result under the wrong register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      doneCh <= 2'h0;
    end else begin
      doneCh <= seqChannel;
    end
  end

  // Results: hardware-only writes on each finished conversion [RULE_01] [RULE_05]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 3; i++) begin
        tempRes[i] <= tmc_pkg::TEMP_RESET;
      end
    end else if (seqDone) begin
      tempRes[doneCh] <= feResult;
    end
  end

  // Pairing: a high read freezes the low byte; any other read releases it.
  // The host is expected to fetch the low byte next [RULE_02] [RULE_03]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shadowLow <= 8'h00;
      pairValid <= 1'b0;
      pairCh <= 2'h0;
    end else if (regRead) begin
      if (highOf(pointer) != 3'h0) begin
        shadowLow <= tempRes[pointer[1:0]][7:0];
        pairValid <= 1'b1;
        pairCh <= pointer[1:0];
      end else begin
        pairValid <= 1'b0;
      end
    end else if (regReadNext) begin
      pairValid <= 1'b0;
    end
  end

  // Read data: paired low byte wins over the live value [RULE_02] [RULE_04]
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData <= 8'h00;
      rdValid <= 1'b0;
    end else begin
      rdValid <= regRead || regReadNext;
      if (regRead) begin
        if (pairValid && lowOf(pointer) == {1'b1, pairCh}) begin
          rdData <= shadowLow;
        end else begin
          rdData <= liveValue(pointer);
        end
      end else if (regReadNext) begin
        // Second byte of a two-byte read
        rdData <= pairValid ? shadowLow : liveValue(pointer);
      end
    end
  end

  // Front end controls mirror the sequencer and configuration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      feStart <= 1'b0;
      feChannel <= 2'h0;
      feRangeExtended <= 1'b0;
      series_res_correct_en <= 1'b0;
      busy <= 1'b0;
    end else begin
      feStart <= seqStart;
      feChannel <= seqChannel;
      // Result format follows the range bit [RULE_10]
      feRangeExtended <= configOne[tmc_pkg::CFG1_RANGE_BIT];
      series_res_correct_en <= configTwo[tmc_pkg::CFG2_RES_CORRECT_BIT];
      busy <= seqBusy;
    end
  end

  // Step timing and channel walk [RULE_07] [RULE_17] [RULE_23]
  tmc_sequencer #(
    .CONV_LEN(CONV_LEN),
    .IDLE_UNIT(IDLE_UNIT)
  ) u_seq (
    .clk(clk),
    .sys_rst(sys_rst),
    .chanEn(chanEn),
    .shutdown(shutdown_select),
    .oneShot(oneShot),
    .resCorrect(configTwo[tmc_pkg::CFG2_RES_CORRECT_BIT]),
    .rateCode(rateCode),
    .busy(seqBusy),
    .convStart(seqStart),
    .convDone(seqDone),
    .convChannel(seqChannel)
  );

  // Helper: set once any conversion has landed
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      everDone <= 1'b0;
    end else if (seqDone) begin
      everDone <= 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_RESULT_UPDATE: assert property (seqDone |=> tempRes[$past(doneCh)] == $past(feResult)) // [RULE_01]
    else $error("Result not captured at conversion end");
  AST_PAIRED_LOW: assert property (regRead && highOf(pointer) != 3'h0 ##1 regRead && lowOf(pointer) == {1'b1, pairCh}
    |=> rdData == $past(shadowLow)) // [RULE_02]
    else $error("Low byte not from the paired conversion");
  AST_TWO_BYTE: assert property (regRead && highOf(pointer) != 3'h0 ##1 regReadNext
    |=> rdData == $past(tempRes[pointer[1:0]][7:0], 2)) // [RULE_04]
    else $error("Two-byte read mixed conversions");
  AST_RESET_ZERO: assert property (!everDone |-> tempRes[0] == 16'h0 && tempRes[1] == 16'h0 && tempRes[2] == 16'h0) // [RULE_05]
    else $error("Result nonzero before any conversion");
  AST_STATUS: assert property (regRead && pointer == tmc_pkg::PTR_STATUS |=> rdData == {$past(seqBusy), 7'h00}) // [RULE_06]
    else $error("Status read wrong");
  AST_ONESHOT_DROP: assert property (regWrite && pointer == tmc_pkg::PTR_ONE_SHOT |=> oneShot && $stable(configOne)) // [RULE_12]
    else $error("One-shot write misbehaved");
  AST_RATE_STORE: assert property (regWrite && pointer == tmc_pkg::PTR_RATE |=> rateCode == $past(regWrData[2:0])) // [RULE_22]
    else $error("Rate code not stored");
  AST_PTR_LOAD: assert property (ptrWrite |=> pointer == $past(ptrData)) // [RULE_21]
    else $error("Pointer not loaded");
  COV_PAIR: cover property (regRead && highOf(pointer) != 3'h0 ##1 regRead && lowOf(pointer) != 3'h0);
  COV_TWO_BYTE: cover property (regRead ##1 regReadNext);
  COV_SHUTDOWN: cover property (shutdown_select && seqDone ##1 !seqBusy);
endmodule

//--- tmc_host_model.sv
// Host model: issues decoded register commands to the monitor.
// Assumes commands are taken on rising clk edges, driven at falling ones.
`timescale 1ns/1ps
module tmc_host_model (
  input wire logic clk,
  output logic ptrWrite,
  output logic [7:0] ptrData,
  output logic regWrite,
  output logic [7:0] regWrData,
  output logic regRead,
  output logic regReadNext,
  input wire logic [7:0] rdData,
  input wire logic rdValid
);
  // Quiet bus at time zero
  initial begin
    ptrWrite = 1'b0;
    ptrData = 8'h00;
    regWrite = 1'b0;
    regWrData = 8'h00;
    regRead = 1'b0;
    regReadNext = 1'b0;
  end
  // Pointer load, then the data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    ptrWrite = 1'b1;
    ptrData = a;
    @(negedge clk);
    ptrWrite = 1'b0;
    ptrData = ~a; // Released lines never keep the old value
    regWrite = 1'b1;
    regWrData = d; // Callers keep reserved bits zero
    @(negedge clk);
    regWrite = 1'b0;
    regWrData = ~d;
  endtask
  // Optional pointer load, high byte, optional second byte
  task automatic rd(input bit ld, input logic [7:0] a, input bit two, output logic [7:0] hi,
                    output logic [7:0] lo);
    if (ld) begin
      @(negedge clk);
      ptrWrite = 1'b1;
      ptrData = a;
    end
    @(negedge clk);
    ptrWrite = 1'b0;
    ptrData = ~a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    regReadNext = two;
    hi = rdValid ? rdData : 8'hxx; // Answer stands for one cycle only
    @(negedge clk);
    regReadNext = 1'b0;
    lo = rdValid ? rdData : 8'hxx;
  endtask
endmodule

//--- temp_monitor_conversion_ctrl_tb_top.sv
// Testbench: drives the register port through the host model, stands in
// for the front end, and judges results against codes it handed out itself.
`timescale 1ns/1ps
module temp_monitor_conversion_ctrl_tb_top;
  localparam int CL = 20; // Short conversion so runs stay brief
  localparam int IU = 8; // Short idle unit
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ptrWrite, regWrite, regRead, regReadNext, rdValid;
  logic [7:0] ptrData, regWrData, rdData;
  logic [15:0] feResult = 16'h0000;
  logic feStart, feRangeExtended, series_res_correct_en, busy;
  logic [1:0] feChannel;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int nStart = 0; // Conversions seen by the front end model
  int gapOn; // Local conversion length with correction on
  logic [7:0] expHi [4]; // Last code handed out per channel
  int stCh [$]; // Channel of each start
  int stCyc [$]; // Cycle of each start

  // 200 MHz clock
  always #2.5 clk = ~clk;

  tmc_host_model host (.clk(clk), .ptrWrite(ptrWrite), .ptrData(ptrData), .regWrite(regWrite),
    .regWrData(regWrData), .regRead(regRead), .regReadNext(regReadNext), .rdData(rdData),
    .rdValid(rdValid));

  tmc_conversion_ctrl #(.DUAL_REMOTE(1'b1), .CONV_LEN(CL), .IDLE_UNIT(IU)) dut (.clk(clk),
    .sys_rst(sys_rst), .ptrWrite(ptrWrite), .ptrData(ptrData), .regWrite(regWrite),
    .regWrData(regWrData), .regRead(regRead), .regReadNext(regReadNext), .rdData(rdData),
    .rdValid(rdValid), .feResult(feResult), .feStart(feStart), .feChannel(feChannel),
    .feRangeExtended(feRangeExtended), .series_res_correct_en(series_res_correct_en), .busy(busy));

  // Front end: logs each start and hands out a fresh code per conversion
  always @(posedge clk) begin
    cyc++;
    if (feStart === 1'b1) begin
      nStart++;
      expHi[feChannel] = 8'(nStart);
      stCh.push_back(int'(feChannel));
      stCyc.push_back(cyc);
    end
  end
  // Upper nibble of the low byte also follows the count, so a stale low byte shows
  always @(negedge clk) feResult <= {8'(nStart), 4'(nStart), 4'h0};

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts and cycle spans
  task automatic chkn(input int got, input int exp);
    compares++;
    if (got != exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait; running out ends the run
  task automatic waitBusy(input logic v, input int lim);
    int i;
    i = 0;
    while (busy !== v && i < lim) begin
      @(negedge clk);
      i++;
    end
    if (busy !== v) begin
      n_fail++;
      $display("BAD t=%0t busy=%h want=%h", $time, busy, v);
      print_verdict();
    end
  endtask
  task automatic print_verdict();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic t_reset();
    logic [7:0] h, l;
    host.rd(1'b0, 8'h00, 1'b0, h, l); // No pointer load: reset pointer used
    chk(h, 8'h00);
    chk({7'h0, busy}, 8'h01);
    host.rd(1'b1, tmc_pkg::PTR_STATUS, 1'b0, h, l);
    chk(h, 8'h80);
    host.rd(1'b1, tmc_pkg::PTR_CONFIG_ONE, 1'b0, h, l);
    chk(h, 8'h00);
    host.rd(1'b1, tmc_pkg::PTR_CONFIG_TWO, 1'b0, h, l);
    chk(h, 8'h3c);
    host.rd(1'b1, tmc_pkg::PTR_RATE, 1'b0, h, l);
    chk(h, 8'h07);
    chk({7'h0, series_res_correct_en}, 8'h01);
    $display("reset test done");
  endtask

  task automatic t_shutdown();
    logic [7:0] h, l;
    int n0;
    host.wr(tmc_pkg::PTR_CONFIG_ONE, 8'h44);
    @(negedge clk);
    chk({7'h0, feRangeExtended}, 8'h01);
    waitBusy(1'b0, 400);
    n0 = nStart;
    repeat (100) @(negedge clk);
    chkn(nStart, n0);
    host.rd(1'b1, tmc_pkg::PTR_STATUS, 1'b0, h, l);
    chk(h, 8'h00);
    host.rd(1'b1, tmc_pkg::PTR_CONFIG_ONE, 1'b0, h, l);
    chk(h, 8'h44);
    $display("shutdown test done");
  endtask

  // One pass per trigger; a second trigger mid-pass must vanish
  task automatic t_oneshot();
    logic [7:0] h, l;
    stCh.delete();
    stCyc.delete();
    host.wr(tmc_pkg::PTR_ONE_SHOT, 8'ha5);
    waitBusy(1'b1, 6);
    host.wr(tmc_pkg::PTR_ONE_SHOT, 8'h5a);
    waitBusy(1'b0, 200);
    repeat (50) @(negedge clk);
    chkn(stCh.size(), 3);
    for (int i = 0; i < 3; i++) chkn(stCh[i], i);
    gapOn = stCyc[1] - stCyc[0];
    host.rd(1'b1, tmc_pkg::PTR_ONE_SHOT, 1'b0, h, l);
    chk(h, 8'h00);
    $display("one-shot test done");
  endtask

  task automatic t_results();
    logic [7:0] h, l, old;
    for (int i = 0; i < 3; i++) begin
      host.rd(1'b1, 8'(i), 1'b1, h, l);
      chk(h, expHi[i]);
      chk(l, {expHi[i][3:0], 4'h0});
    end
    host.wr(tmc_pkg::PTR_LOCAL_HIGH, 8'hff); // Read-only, must not stick
    host.rd(1'b1, tmc_pkg::PTR_LOCAL_HIGH, 1'b0, h, l);
    chk(h, expHi[0]);
    host.rd(1'b1, 8'h30, 1'b0, h, l); // Unmapped place reads zero
    chk(h, 8'h00);
    // High byte read, then a new pass, then the low byte
    old = expHi[1];
    host.rd(1'b1, tmc_pkg::PTR_REMOTE1_HIGH, 1'b0, h, l);
    host.wr(tmc_pkg::PTR_ONE_SHOT, 8'h00);
    waitBusy(1'b1, 6);
    waitBusy(1'b0, 200);
    host.rd(1'b1, tmc_pkg::PTR_REMOTE1_LOW, 1'b0, h, l);
    chk(h, {old[3:0], 4'h0});
    host.rd(1'b1, tmc_pkg::PTR_STATUS, 1'b0, h, l);
    host.rd(1'b1, tmc_pkg::PTR_REMOTE1_LOW, 1'b0, h, l);
    chk(h, {expHi[1][3:0], 4'h0});
    $display("result test done");
  endtask

  // Remote 1 off, correction off: shorter local conversion
  task automatic t_channels();
    logic [7:0] h, l;
    host.wr(tmc_pkg::PTR_CONFIG_TWO, 8'h28);
    @(negedge clk);
    chk({7'h0, series_res_correct_en}, 8'h00);
    host.rd(1'b1, tmc_pkg::PTR_CONFIG_TWO, 1'b0, h, l);
    chk(h, 8'h28);
    stCh.delete();
    stCyc.delete();
    host.wr(tmc_pkg::PTR_ONE_SHOT, 8'h00);
    waitBusy(1'b1, 6);
    waitBusy(1'b0, 200);
    chkn(stCh.size(), 2);
    chkn(stCh[0], 0);
    chkn(stCh[1], 2);
    chkn(gapOn - (stCyc[1] - stCyc[0]), CL / 2);
    host.wr(tmc_pkg::PTR_CONFIG_TWO, 8'h3c);
    $display("channel test done");
  endtask

  // Pass period in continuous mode at one rate code
  task automatic period(input logic [7:0] r, output int p);
    int i;
    host.wr(tmc_pkg::PTR_CONFIG_ONE, 8'h40);
    waitBusy(1'b0, 400);
    host.wr(tmc_pkg::PTR_RATE, r);
    stCh.delete();
    stCyc.delete();
    host.wr(tmc_pkg::PTR_CONFIG_ONE, 8'h00);
    i = 0;
    while (stCyc.size() < 4 && i < 3000) begin
      @(negedge clk);
      i++;
    end
    chkn(stCyc.size(), 4);
    if (stCyc.size() < 4) print_verdict();
    chkn(stCh[3], 0);
    chkn(stCyc[1] - stCyc[0], gapOn);
    p = stCyc[3] - stCyc[0];
  endtask

  task automatic t_rate();
    int p7, p6, p0;
    period(8'h07, p7);
    period(8'h06, p6);
    period(8'h00, p0);
    chkn(p6 - p7, IU);
    chkn(p0 - p7, (IU << 7) - IU);
    waitBusy(1'b0, 200);
    repeat (20) @(negedge clk);
    host.wr(tmc_pkg::PTR_ONE_SHOT, 8'h00);
    waitBusy(1'b1, 6);
    $display("rate test done");
  endtask

  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_shutdown();
    t_oneshot();
    t_results();
    t_channels();
    t_rate();
    print_verdict();
  end
endmodule
